// ==== sim/codec_multifunction_pins_test.sv ====
// self-checking bench of the multifunction pin block
`timescale 1ns/10ps
`include "pin_mux_consts.svh"
module codec_multifunction_pins_test;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic [4:0] src; logic [2:0] oe, out;} row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ctrl_is_i2c = 1'b1, rdy_q;
  logic adc_wclk = 1'b0, ref_clk_div = 1'b0, alt_wclk = 1'b0, dmic_clk = 1'b0, alt_bus_out = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd_q, r;
  logic [2:0] ev = 3'h0;
  logic [4:0] ext = 5'h00;
  logic hreadyout, hresp, irq, dmic_data, alt_data_in, aux_pin_0, aux_pin_1, aux_pin_3;
  logic general_pin_a_in, general_pin_a_out, general_pin_a_oe_n, aux_pin_2, aux_pin_2_oe_n;
  logic general_pin_b_in, general_pin_b_out, general_pin_b_oe_n, alt_bus_in;
  int n_fail = 0, samples_checked = 0;
  // rows: offset, write, readback, sources {adc,ref,alt,dmic,bus}, oe_n and out of {a,b,aux2}
  row_t rows [13] = '{'{8'h00, 32'h87, 32'h87, 5'h00, 3'h3, 3'h4},
    '{8'h00, 32'h07, 32'h07, 5'h1F, 3'h3, 3'h0}, '{8'h00, 32'h01, 32'h01, 5'h10, 3'h3, 3'h4},
    '{8'h00, 32'h02, 32'h02, 5'h17, 3'h3, 3'h0}, '{8'h00, 32'h04, 32'h04, 5'h04, 3'h3, 3'h4},
    '{8'h00, 32'h05, 32'h05, 5'h02, 3'h3, 3'h4}, '{8'h00, 32'h09, 32'h00, 5'h1F, 3'h7, 3'h0},
    '{8'h04, 32'h87, 32'h87, 5'h00, 3'h5, 3'h2}, '{8'h04, 32'h05, 32'h00, 5'h00, 3'h7, 3'h0},
    '{8'h08, 32'h06, 32'h06, 5'h00, 3'h6, 3'h1}, '{8'h08, 32'h02, 32'h02, 5'h00, 3'h6, 3'h0},
    '{8'h40, 32'hFFFFFFFF, 32'h0, 5'h00, 3'h6, 3'h0}, '{8'h08, 32'h00, 32'h00, 5'h00, 3'h7, 3'h0}};

  codec_multifunction_pins DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .adc_wclk, .ref_clk_div, .alt_wclk,
    .dmic_clk, .alt_bus_out, .hp_short_event(ev[0]), .agc_noise_event(ev[1]),
    .jack_detect_event(ev[2]), .ctrl_is_i2c, .general_pin_a_in, .general_pin_a_out,
    .general_pin_a_oe_n, .general_pin_b_in, .general_pin_b_out, .general_pin_b_oe_n, .aux_pin_0,
    .aux_pin_1, .aux_pin_2, .aux_pin_2_oe_n, .aux_pin_3, .dmic_data, .alt_bus_in, .alt_data_in,
    .irq);
  far_side_model peer (.a_out(general_pin_a_out), .a_oe_n(general_pin_a_oe_n),
    .b_out(general_pin_b_out), .b_oe_n(general_pin_b_oe_n), .ext, .a_in(general_pin_a_in),
    .b_in(general_pin_b_in), .aux0(aux_pin_0), .aux1(aux_pin_1), .aux3(aux_pin_3));

  initial forever #2.5 hclk = ~hclk;
  // bus answers as seen at the edge, free of races with the design's updates
  always @(posedge hclk) begin
    rdy_q <= hreadyout;
    rd_q <= hrdata;
  end
  task automatic tick;
    @(posedge hclk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single-word transfer, waiting on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do tick; while (rdy_q !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do tick; while (rdy_q !== 1'b1);
    r = rd_q;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cut a hang short well beyond the some 140 cycles the tests need
  initial begin
    #50000;
    n_fail++;
    conclude;
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    tick;
    rd(`OFF_IRQ_STATUS, 32'h0);
    foreach (rows[i]) begin
      {adc_wclk, ref_clk_div, alt_wclk, dmic_clk, alt_bus_out} <= rows[i].src;
      xfer(1'b1, rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
      check({general_pin_a_oe_n, general_pin_b_oe_n, aux_pin_2_oe_n}, rows[i].oe);
      check({general_pin_a_out, general_pin_b_out, aux_pin_2} & ~rows[i].oe, rows[i].out);
    end
    for (int k = 0; k < 2; k++) begin
      ctrl_is_i2c <= k[0];
      rd(`OFF_CTRL_IF, k);
    end
    // levels of inputs, then microphone data on pin b
    xfer(1'b1, `OFF_PIN_A_CFG, 32'h06);
    xfer(1'b1, `OFF_PIN_B_CFG, 32'h06);
    xfer(1'b1, `OFF_AUX_CFG, 32'h01);
    for (int j = 0; j < 2; j++) begin
      ext <= j ? 5'h0A : 5'h15;
      tick;
      rd(`OFF_PIN_LEVELS, {ext[4:2], 1'b0, ext[1:0]});
      check(alt_data_in, ext[4]);
    end
    xfer(1'b1, `OFF_AUX_CFG, 32'h00);
    check(alt_data_in, 1'b0);
    xfer(1'b1, `OFF_PIN_B_CFG, 32'h09);
    check(dmic_data, ext[1]);
    // pin b as alternate bus line: it drives, and the routed input follows it
    alt_bus_out <= 1'b1;
    xfer(1'b1, `OFF_PIN_B_CFG, 32'h08);
    check(alt_bus_in, 1'b1);
    check(dmic_data, 1'b0);
    check(hresp, 1'b0);
    // each event sets its status bit and, while enabled, the interrupt; the clear drops both
    xfer(1'b1, `OFF_IRQ_ENABLE, 32'h7);
    xfer(1'b1, `OFF_PIN_A_CFG, 32'h03);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) xfer(1'b1, `OFF_IRQ_ENABLE, 32'h0);
      ev <= 3'h1 << (i % 3);
      repeat (3) tick;
      ev <= 3'h0;
      rd(`OFF_IRQ_STATUS, 32'h1 << (i % 3));
      check(irq, i < 3);
      xfer(1'b1, `OFF_IRQ_CLEAR, 32'h7);
      rd(`OFF_IRQ_STATUS, 32'h0);
      check(irq, 1'b0);
    end
    // the single pulse lasts 2 ms, so it still stands here
    check({general_pin_a_out, general_pin_a_oe_n}, 2'b10);
    // pin b in repeating mode on the noise event starts its train on the edge
    xfer(1'b1, `OFF_PIN_B_CFG, 32'h53);
    ev <= 3'h2;
    repeat (2) tick;
    check({general_pin_b_out, general_pin_b_oe_n}, 2'b10);
    // reset in mid-run releases every pin and drops the config
    ev <= 3'h0;
    hresetn <= 1'b0;
    tick;
    check({general_pin_a_oe_n, general_pin_b_oe_n, aux_pin_2_oe_n, irq}, 4'hE);
    hresetn <= 1'b1;
    tick;
    rd(`OFF_PIN_B_CFG, 32'h0);
    conclude;
  end
endmodule

// ==== sim/far_side_model.sv ====
// external devices on the general and aux pins
`timescale 1ns/10ps
module far_side_model (
  // design side of the two-way pins
  input wire logic a_out,
  input wire logic a_oe_n,
  input wire logic b_out,
  input wire logic b_oe_n,
  // levels the outside world puts on {aux3, aux1, aux0, b, a}
  input wire logic [4:0] ext,
  // resolved wire levels
  output logic a_in,
  output logic b_in,
  output logic aux0,
  output logic aux1,
  output logic aux3
);
  // a driven pin reads back the block's own level, else the outside level
  assign a_in = a_oe_n ? ext[0] : a_out;
  assign b_in = b_oe_n ? ext[1] : b_out;
  assign {aux3, aux1, aux0} = ext[4:2];
endmodule

// ==== sim/pins_chk.sv ====
// concurrent checks on the ports of the multifunction pin block
`timescale 1ns/10ps
module pins_chk (
  // clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // pins and routed lines
  input wire logic general_pin_a_oe_n,
  input wire logic general_pin_b_oe_n,
  input wire logic aux_pin_2_oe_n,
  input wire logic aux_pin_3,
  input wire logic general_pin_b_in,
  input wire logic dmic_data,
  input wire logic alt_data_in,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address phase taken for one direction and offset
  sequence taken(logic w);
    hsel && hready && htrans[1] && hwrite == w;
  endsequence
  sequence read_at(logic [7:0] a);
    taken(1'b0) ##0 haddr == a;
  endsequence
  a_bus_ready: assert property (hreadyout) else $error("slave stalled");
  a_write_rdata_zero: assert property (taken(1'b1) |=> hrdata == 32'h0)
    else $error("read data after write not zero");
  a_status_three_bits: assert property (read_at(8'h10) |=> hrdata[31:3] == 29'h0)
    else $error("status has more than three sources");
  a_level_layout: assert property (read_at(8'h0C) |=> !hrdata[2] && hrdata[31:6] == 26'h0)
    else $error("level word has stray bits");
  a_ctrl_one_bit: assert property (read_at(8'h1C) |=> hrdata[31:1] == 31'h0)
    else $error("control word has stray bits");
  a_alt_data_gate: assert property (alt_data_in |-> aux_pin_3)
    else $error("alternate data without pin level");
  a_dmic_route: assert property (dmic_data |-> general_pin_b_in)
    else $error("microphone data without pin level");
  // no pin may drive and no interrupt may show straight after reset
  a_reset_pins_quiet: assert property ($rose(hresetn) |-> !irq ##0
    (general_pin_a_oe_n && general_pin_b_oe_n && aux_pin_2_oe_n)) else $error("pin driven after reset");
endmodule
bind codec_multifunction_pins pins_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .general_pin_a_oe_n, .general_pin_b_oe_n, .aux_pin_2_oe_n,
  .aux_pin_3, .general_pin_b_in, .dmic_data, .alt_data_in, .irq);

// ==== src/codec_multifunction_pins.sv ====
// multifunction and general pin logic with AHB-Lite register slave
//
// How it works
// - pin a offers seven roles
// - interrupt pin signals short, noise, jack
// - single 2ms pulse or repeating pulses
// - general input level readable as status
// - general output drives written level
// - pin b offers five roles
// - pin b behaves like pin a
// - i2c pins stay dedicated, no alternates
// - aux pin 3 input or alternate data
// - aux pin 2 disabled or output level
// - aux pins 0,1,3 levels readable
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "pin_mux_consts.svh"
module codec_multifunction_pins
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // internal sources for pin roles
  input wire logic adc_wclk,
  input wire logic ref_clk_div,
  input wire logic alt_wclk,
  input wire logic dmic_clk,
  input wire logic alt_bus_out,
  // codec events
  input wire logic hp_short_event,
  input wire logic agc_noise_event,
  input wire logic jack_detect_event,
  // control interface strap (high means i2c)
  input wire logic ctrl_is_i2c,
  // general pin a, output enable low means driving
  input wire logic general_pin_a_in,
  output logic general_pin_a_out,
  output logic general_pin_a_oe_n,
  // general pin b
  input wire logic general_pin_b_in,
  output logic general_pin_b_out,
  output logic general_pin_b_oe_n,
  // aux pins
  input wire logic aux_pin_0,
  input wire logic aux_pin_1,
  output logic aux_pin_2,
  output logic aux_pin_2_oe_n,
  input wire logic aux_pin_3,
  // routed data to codec
  output logic dmic_data,
  output logic alt_bus_in,
  output logic alt_data_in,
  // interrupt to host
  output logic irq
);

  typedef struct packed {
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [2:0] aux_cfg;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [2:0] ev_prev;
    pulse_state_t ps_a;
    pulse_state_t ps_b;
    logic [19:0] cnt_a;
    logic [19:0] cnt_b;
    logic dph_write;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // pulse generator step: single or repeating train while event is present
  // trig is the rising edge of the chosen event, hold its level
  // single mode ends after one high phase; its low phase lasts one cycle
  function automatic logic [22:0] pulse_step(input pulse_state_t ps, input logic [19:0] cnt,
                                             input logic trig, input logic hold,
                                             input logic repeat_mode);
    pulse_state_t ns;
    logic [19:0] nc;
    ns = ps;
    nc = cnt;
    case (ps)
      PS_IDLE: begin
        if (trig) begin
          ns = PS_HIGH;
          nc = 20'h00000;
        end
      end
      PS_HIGH: begin
        if (cnt == 20'(`PULSE_CYCLES - 1)) begin
          ns = PS_LOW;
          nc = 20'h00000;
        end else begin
          nc = cnt + 20'h00001;
        end
      end
      PS_LOW: begin
        // single mode stops; repeating mode keeps pulsing while event holds
        if (!repeat_mode || !hold) begin
          ns = PS_IDLE;
        end else if (cnt == 20'(`PULSE_CYCLES - 1)) begin
          ns = PS_HIGH;
          nc = 20'h00000;
        end else begin
          nc = cnt + 20'h00001;
        end
      end
      default: begin
        ns = PS_IDLE;
      end
    endcase
    return {ns, nc};
  endfunction

  // role field of a pin config byte
  function automatic pin_func_t role_of(input logic [7:0] cfg);
    role_of = pin_func_t'(cfg[`CFG_FUNC_LSB +: 4]);
  endfunction

  // selects the driven level of a general pin for its role
  // sources come in as an argument so that a change on them re-evaluates the pin
  function automatic logic pin_drive(input logic [7:0] cfg, input logic pulse_hi,
                                     input logic [4:0] src);
    case (role_of(cfg))
      FN_ADC_WCLK: pin_drive = src[4];
      FN_CLK_OUT: pin_drive = src[3];
      FN_IRQ: pin_drive = pulse_hi;
      FN_ALT_WCLK: pin_drive = src[2];
      FN_DMIC_CLK: pin_drive = src[1];
      FN_ALT_BUS: pin_drive = src[0];
      FN_GP_OUT: pin_drive = cfg[`CFG_LEVEL_BIT];
      default: pin_drive = 1'b0;
    endcase
  endfunction

  // roles that turn the pin driver on; all others leave the pad to the outside
  function automatic logic is_out_role(input logic [7:0] cfg);
    pin_func_t f;
    f = pin_func_t'(cfg[`CFG_FUNC_LSB +: 4]);
    return (f == FN_ADC_WCLK) || (f == FN_CLK_OUT) || (f == FN_IRQ) ||
           (f == FN_ALT_WCLK) || (f == FN_DMIC_CLK) || (f == FN_GP_OUT) ||
           (f == FN_ALT_BUS);
  endfunction

  // picks one event bit by source code; the spare code selects nothing
  function automatic logic src_hit(input logic [2:0] ev, input logic [1:0] src);
    src_hit = 1'b0;
    if (src < 2'(`IRQ_SRC_COUNT)) begin
      src_hit = ev[src];
    end
  endfunction

  // legal role per pin; illegal writes fall back to disabled
  function automatic logic [3:0] legal_a(input logic [3:0] f);
    if (f <= 4'(FN_GP_OUT)) begin
      legal_a = f;
    end else begin
      legal_a = 4'(FN_DISABLED);
    end
  endfunction

  function automatic logic [3:0] legal_b(input logic [3:0] f);
    if (f == 4'(FN_ALT_BUS) || f == 4'(FN_IRQ) || f == 4'(FN_GP_IN) ||
        f == 4'(FN_GP_OUT) || f == 4'(FN_DMIC_DATA)) begin
      legal_b = f;
    end else begin
      legal_b = 4'(FN_DISABLED);
    end
  endfunction

  logic [2:0] events;
  logic [2:0] ev_rise;
  logic sel_a;
  logic sel_b;
  logic [22:0] step_a;
  logic [22:0] step_b;
  logic addr_phase;
  logic [31:0] levels;
  logic [4:0] src_lv;
  logic rise_a;
  logic rise_b;

  assign events = {jack_detect_event, agc_noise_event, hp_short_event};
  assign ev_rise = events & ~st_reg.ev_prev;
  assign addr_phase = hsel && hready && htrans[1];
  // internal levels a general pin may carry, in one word for the drivers
  assign src_lv = {adc_wclk, ref_clk_div, alt_wclk, dmic_clk, alt_bus_out};

  // chosen event of each interrupt pin: level keeps repeats, edge starts a pulse
  assign sel_a = src_hit(events, st_reg.cfg_a[`CFG_SRC_LSB +: 2]);
  assign sel_b = src_hit(events, st_reg.cfg_b[`CFG_SRC_LSB +: 2]);
  assign rise_a = src_hit(ev_rise, st_reg.cfg_a[`CFG_SRC_LSB +: 2]);
  assign rise_b = src_hit(ev_rise, st_reg.cfg_b[`CFG_SRC_LSB +: 2]);

  // started on the edge only, so a held event cannot restart a single pulse
  assign step_a = pulse_step(st_reg.ps_a, st_reg.cnt_a,
                             rise_a && role_of(st_reg.cfg_a) == FN_IRQ,
                             sel_a, st_reg.cfg_a[`CFG_MODE_BIT]);
  assign step_b = pulse_step(st_reg.ps_b, st_reg.cnt_b,
                             rise_b && role_of(st_reg.cfg_b) == FN_IRQ,
                             sel_b, st_reg.cfg_b[`CFG_MODE_BIT]);

  // input levels read back; pins a and b only shown as general inputs, aux pins 0, 1 and 3 always
  assign levels = {26'h0000000, aux_pin_3, aux_pin_1, aux_pin_0,
                   1'b0,
                   general_pin_b_in && pin_func_t'(st_reg.cfg_b[3:0]) == FN_GP_IN,
                   general_pin_a_in && pin_func_t'(st_reg.cfg_a[3:0]) == FN_GP_IN};

  // next state: bus slave, sticky events, pulse trains
  always_comb begin
    st_next = st_reg;
    st_next.ev_prev = events;
    st_next.ps_a = pulse_state_t'(step_a[22:20]);
    st_next.cnt_a = step_a[19:0];
    st_next.ps_b = pulse_state_t'(step_b[22:20]);
    st_next.cnt_b = step_b[19:0];
    if (st_reg.dph_write) begin
      if (st_reg.dph_addr == `OFF_PIN_A_CFG) begin
        st_next.cfg_a = {hwdata[7:4], legal_a(hwdata[3:0])};
      end else if (st_reg.dph_addr == `OFF_PIN_B_CFG) begin
        st_next.cfg_b = {hwdata[7:4], legal_b(hwdata[3:0])};
      end else if (st_reg.dph_addr == `OFF_AUX_CFG) begin
        st_next.aux_cfg = hwdata[2:0];
      end else if (st_reg.dph_addr == `OFF_IRQ_CLEAR) begin
        st_next.irq_stat = st_reg.irq_stat & ~hwdata[2:0];
      end else if (st_reg.dph_addr == `OFF_IRQ_ENABLE) begin
        st_next.irq_en = hwdata[2:0];
      end
    end
    // set wins over a clear in the same cycle
    st_next.irq_stat = st_next.irq_stat | ev_rise;
    st_next.dph_write = addr_phase && hwrite;
    st_next.dph_addr = addr_phase ? haddr : st_reg.dph_addr;
    // read data is taken in the address phase so it stands through the data phase
    st_next.rdata = 32'h00000000;
    if (addr_phase && !hwrite) begin
      if (haddr == `OFF_PIN_A_CFG) begin
        st_next.rdata = {24'h000000, st_reg.cfg_a};
      end else if (haddr == `OFF_PIN_B_CFG) begin
        st_next.rdata = {24'h000000, st_reg.cfg_b};
      end else if (haddr == `OFF_AUX_CFG) begin
        st_next.rdata = {29'h00000000, st_reg.aux_cfg};
      end else if (haddr == `OFF_PIN_LEVELS) begin
        st_next.rdata = levels;
      end else if (haddr == `OFF_IRQ_STATUS) begin
        st_next.rdata = {29'h00000000, st_reg.irq_stat};
      end else if (haddr == `OFF_IRQ_ENABLE) begin
        st_next.rdata = {29'h00000000, st_reg.irq_en};
      end else if (haddr == `OFF_CTRL_IF) begin
        st_next.rdata = {31'h00000000, ctrl_is_i2c};
      end
    end
  end

  // async reset leaves every pin released and the interrupt low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '{cfg_a: 8'h00, cfg_b: 8'h00, aux_cfg: 3'h0, irq_stat: 3'h0,
                 irq_en: 3'h0, ev_prev: 3'h0, ps_a: PS_IDLE, ps_b: PS_IDLE,
                 cnt_a: 20'h00000, cnt_b: 20'h00000, dph_write: 1'b0,
                 dph_addr: 8'h00, rdata: 32'h00000000};
    end else begin
      st_reg <= st_next;
    end
  end

  // bus answers in zero wait states, always okay
  // hsize is not decoded: only whole aligned words are mapped
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign irq = |(st_reg.irq_stat & st_reg.irq_en);

  // pin drivers; roles are decoded from registered config
  assign general_pin_a_out = pin_drive(st_reg.cfg_a, st_reg.ps_a == PS_HIGH,
                                       src_lv);
  assign general_pin_a_oe_n = !is_out_role(st_reg.cfg_a);
  assign general_pin_b_out = pin_drive(st_reg.cfg_b, st_reg.ps_b == PS_HIGH,
                                       src_lv);
  assign general_pin_b_oe_n = !is_out_role(st_reg.cfg_b);
  assign dmic_data = general_pin_b_in && pin_func_t'(st_reg.cfg_b[3:0]) == FN_DMIC_DATA;
  assign alt_bus_in = general_pin_b_in && pin_func_t'(st_reg.cfg_b[3:0]) == FN_ALT_BUS;
  // i2c pins are not muxed here at all, so they stay dedicated
  assign aux_pin_2 = st_reg.aux_cfg[`AUX2_LEVEL_BIT] && st_reg.aux_cfg[`AUX2_EN_BIT];
  assign aux_pin_2_oe_n = !st_reg.aux_cfg[`AUX2_EN_BIT];
  assign alt_data_in = aux_pin_3 && st_reg.aux_cfg[`AUX3_FUNC_BIT];
  // no alternate role exists for the control-interface pins in this block

endmodule

// ==== src/pin_mux_consts.svh ====
// register offsets, field positions and timing counts of the multifunction pin block
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define OFF_PIN_A_CFG 8'h00
`define OFF_PIN_B_CFG 8'h04
`define OFF_AUX_CFG 8'h08
`define OFF_PIN_LEVELS 8'h0C
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_CLEAR 8'h14
`define OFF_IRQ_ENABLE 8'h18
`define OFF_CTRL_IF 8'h1C
// pin config: [3:0] function, [5:4] irq source, [6] pulse mode, [7] output level
`define CFG_FUNC_LSB 0
`define CFG_SRC_LSB 4
`define CFG_MODE_BIT 6
`define CFG_LEVEL_BIT 7
// aux config: [0] aux3 function, [1] aux2 output enable, [2] aux2 level
`define AUX3_FUNC_BIT 0
`define AUX2_EN_BIT 1
`define AUX2_LEVEL_BIT 2
`define PULSE_NS 2000000
`define CLK_NS 5
`define PULSE_CYCLES ((`PULSE_NS) / (`CLK_NS))
// repeat pulses: high 2 ms, low 2 ms
`define IRQ_SRC_COUNT 3
`endif

// ==== src/pin_mux_pkg.sv ====
// types of the multifunction pin block
package pin_mux_pkg;
  typedef enum logic [3:0] {
    FN_DISABLED = 4'h0,
    FN_ADC_WCLK = 4'h1,
    FN_CLK_OUT = 4'h2,
    FN_IRQ = 4'h3,
    FN_ALT_WCLK = 4'h4,
    FN_DMIC_CLK = 4'h5,
    FN_GP_IN = 4'h6,
    FN_GP_OUT = 4'h7,
    FN_ALT_BUS = 4'h8,
    FN_DMIC_DATA = 4'h9
  } pin_func_t;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_HIGH = 3'b010,
    PS_LOW = 3'b100
  } pulse_state_t;
endpackage
